// ==== ept_trigger_handshake.sv ====
// Program trigger handshake: start detection, run tracking, completion and result pins.
// Summary of operation
// (R1) A low pulse on the start input begins a run just as the program button does.
// (R2) The controller holds the start input low between 10 ms and 500 ms.
// (R3) On completion the done output goes low for a pulse between 12 ms and 100 ms.
// (R4) The controller watches the done output and takes a low pulse as run completion.
// (R5) The result lines are valid only while the done pulse is low.
// (R6) The first result line goes low in the done pulse when programming passed.
// (R7) The fourth result line goes low in the done pulse on a not-blank failure.
// (R8) Trigger, done and result pins act only while the enable jumper is shorted; a done pulse already begun runs to its end if the jumper opens.
// (R9) A plain button across the connector also starts a run, without result reporting.
// (R10) Idle pins stay high and start requests during a run are ignored.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ept_map.svh"

module ept_trigger_handshake (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Connector pins.
    input  wire logic        ext_start_in_n,
    input  wire logic        button_in_n,
    input  wire logic        digital_ctrl_enable_jumper,
    output logic             run_done_pulse_n,
    output logic [6:0]       result_lines_n,
    // Programming engine.
    output logic             run_start,
    output logic             run_busy,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt.
    output logic             irq
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] extSync_reg;
    logic [2:0] btnSync_reg;
    logic [2:0] jmpSync_reg;
    logic       extLvl_reg;
    logic       btnLvl_reg;
    logic       jmpLvl_reg;

    // A level counts only once stages two and three agree.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            extSync_reg <= 3'h7;
            btnSync_reg <= 3'h7;
            jmpSync_reg <= 3'h0;
            extLvl_reg  <= 1'b1;
            btnLvl_reg  <= 1'b1;
            jmpLvl_reg  <= 1'b0;
        end else begin
            extSync_reg <= {extSync_reg[1:0], ext_start_in_n};
            btnSync_reg <= {btnSync_reg[1:0], button_in_n};
            jmpSync_reg <= {jmpSync_reg[1:0], digital_ctrl_enable_jumper};
            if (extSync_reg[1] == extSync_reg[2]) begin
                extLvl_reg <= extSync_reg[2];
            end
            if (btnSync_reg[1] == btnSync_reg[2]) begin
                btnLvl_reg <= btnSync_reg[2];
            end
            if (jmpSync_reg[1] == jmpSync_reg[2]) begin
                jmpLvl_reg <= jmpSync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Start pulse qualification
    // ------------------------------------------------------------
    ept_pkg::ept_cnt_t lowCnt_reg;
    logic              extPrev_reg;
    logic              btnPrev_reg;
    logic              trigReq;
    logic              btnReq;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lowCnt_reg  <= '0;
            extPrev_reg <= 1'b1;
            btnPrev_reg <= 1'b1;
        end else begin
            extPrev_reg <= extLvl_reg;
            btnPrev_reg <= btnLvl_reg;
            if (extLvl_reg) begin
                lowCnt_reg <= '0;
            end else if (lowCnt_reg != ept_pkg::ept_cnt_t'(`EPT_START_MAX_CYC)) begin
                lowCnt_reg <= lowCnt_reg + 27'h1;
            end
        end
    end

    // Pulses shorter than 10 ms are glitches; longer than 500 ms are a stuck line.
    assign trigReq = jmpLvl_reg && extLvl_reg && !extPrev_reg              // see (R1) (R8)
                   && lowCnt_reg >= ept_pkg::ept_cnt_t'(`EPT_START_MIN_CYC)   // see (R2)
                   && lowCnt_reg <  ept_pkg::ept_cnt_t'(`EPT_START_MAX_CYC);
    assign btnReq  = !btnLvl_reg && btnPrev_reg;                             // see (R9)

    // ------------------------------------------------------------
    // Run sequencer
    // ------------------------------------------------------------
    ept_pkg::ept_state_t state_reg;
    ept_pkg::ept_cnt_t   doneCnt_reg;
    logic                reportRun_reg;
    logic                finishReq;
    logic                finishBlank;
    logic                notBlank_reg;
    logic                rejectEv;

    assign rejectEv = (trigReq || btnReq) && state_reg != ept_pkg::EPT_IDLE;  // see (R10)

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg        <= ept_pkg::EPT_IDLE;
            doneCnt_reg      <= '0;
            reportRun_reg    <= 1'b0;
            run_start        <= 1'b0;
            run_busy         <= 1'b0;
            run_done_pulse_n <= 1'b1;
            result_lines_n   <= `EPT_RESULT_IDLE;
        end else begin
            run_start <= 1'b0;
            case (state_reg)
                ept_pkg::EPT_IDLE: begin
                    if (trigReq || btnReq) begin
                        state_reg     <= ept_pkg::EPT_RUN;       // see (R1) (R9)
                        reportRun_reg <= trigReq;
                        run_start     <= 1'b1;
                        run_busy      <= 1'b1;
                    end
                end
                ept_pkg::EPT_RUN: begin
                    if (finishReq) begin
                        run_busy <= 1'b0;
                        if (reportRun_reg && jmpLvl_reg) begin  // see (R8) (R9)
                            state_reg        <= ept_pkg::EPT_DONE;
                            doneCnt_reg      <= '0;
                            run_done_pulse_n <= 1'b0;           // see (R3)
                            result_lines_n   <= `EPT_RESULT_IDLE;
                            // The outcome comes from the finishing write itself; the stored
                            // copy only takes it at this same edge.
                            result_lines_n[`EPT_PASS_BIT]     <= finishBlank;    // see (R6)
                            result_lines_n[`EPT_NOTBLANK_BIT] <= !finishBlank;   // see (R7)
                        end else begin
                            state_reg <= ept_pkg::EPT_IDLE;
                        end
                    end
                end
                ept_pkg::EPT_DONE: begin
                    if (doneCnt_reg == ept_pkg::ept_cnt_t'(`EPT_DONE_CYC - 1)) begin
                        state_reg        <= ept_pkg::EPT_IDLE;
                        run_done_pulse_n <= 1'b1;               // see (R10) (R5)
                        result_lines_n   <= `EPT_RESULT_IDLE;
                    end else begin
                        doneCnt_reg <= doneCnt_reg + 27'h1;
                    end
                end
                default: begin
                    state_reg <= ept_pkg::EPT_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // APB registers and interrupt
    // ------------------------------------------------------------
    logic                  apbWr;
    logic                  apbRd;
    logic [`EPT_IRQ_W-1:0] irqStat_reg;
    logic [`EPT_IRQ_W-1:0] irqMask_reg;
    logic [`EPT_IRQ_W-1:0] irqEv;

    function automatic logic hitAddr(input logic [11:0] a, input logic [11:0] off);
        hitAddr = (a == off);
    endfunction

    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && penable && !pwrite;
    // Software writes the finish strobe with the outcome; the run engine has no other path.
    assign finishReq = apbWr && hitAddr(paddr, `EPT_OFF_CTRL) && pwdata[`EPT_CTRL_FINISH];
    assign finishBlank = pwdata[`EPT_CTRL_NOTBLANK];
    assign irqEv = {rejectEv, finishReq && state_reg == ept_pkg::EPT_RUN,
                    run_start};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            notBlank_reg <= 1'b0;
        end else if (finishReq) begin
            notBlank_reg <= pwdata[`EPT_CTRL_NOTBLANK];
        end
    end

    // A read clears status, but an event in the same cycle is kept.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqStat_reg <= '0;
            irqMask_reg <= '0;
        end else begin
            if (apbRd && hitAddr(paddr, `EPT_OFF_IRQ_STAT)) begin
                // Only the bits already handed out in prdata are cleared, so an event
                // that lands between setup and access is not lost.
                irqStat_reg <= (irqStat_reg & ~prdata[`EPT_IRQ_W-1:0]) | irqEv;
            end else begin
                irqStat_reg <= irqStat_reg | irqEv;
            end
            if (apbWr && hitAddr(paddr, `EPT_OFF_IRQ_MASK)) begin
                irqMask_reg <= pwdata[`EPT_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_reg & irqMask_reg);
        end
    end

    // Zero wait states: pready rises in the access cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel && !penable) begin
                if (hitAddr(paddr, `EPT_OFF_CTRL)) begin
                    prdata <= {31'h0, notBlank_reg} << `EPT_CTRL_NOTBLANK;
                end else if (hitAddr(paddr, `EPT_OFF_STATUS)) begin
                    prdata <= {28'h0, jmpLvl_reg, reportRun_reg, state_reg};
                end else if (hitAddr(paddr, `EPT_OFF_IRQ_STAT)) begin
                    prdata <= {29'h0, irqStat_reg};
                end else if (hitAddr(paddr, `EPT_OFF_IRQ_MASK)) begin
                    prdata <= {29'h0, irqMask_reg};
                end else if (hitAddr(paddr, `EPT_OFF_RESULT)) begin
                    prdata <= {24'h0, run_done_pulse_n, result_lines_n};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Counts the cycles the done pin has been low; it clears while the pin is high.
    logic [27:0] lowLen_reg;
    always_ff @(posedge clock) begin
        if (sys_rst || run_done_pulse_n) begin
            lowLen_reg <= '0;
        end else begin
            lowLen_reg <= lowLen_reg + 28'h1;
        end
    end

    a_start_on_trig: assert property ( // see (R1)
        trigReq && state_reg == ept_pkg::EPT_IDLE |=> run_start && run_busy)
        else $error("trigger did not start a run");
    a_start_single: assert property (run_start |=> !run_start) // see (R1)
        else $error("start pulse longer than one cycle");
    a_start_width_min: assert property ( // see (R2)
        trigReq |-> $past(lowCnt_reg) >= ept_pkg::ept_cnt_t'(`EPT_START_MIN_CYC - 1))
        else $error("short start pulse accepted");
    a_start_width_max: assert property ( // see (R2)
        trigReq |-> lowCnt_reg < ept_pkg::ept_cnt_t'(`EPT_START_MAX_CYC))
        else $error("long start pulse accepted");
    a_done_width: assert property ( // see (R3)
        $rose(run_done_pulse_n) |-> $past(lowLen_reg) == 28'(`EPT_DONE_CYC - 1))
        else $error("done pulse width wrong");
    // The window is checked apart from the drive width, so a drive width moved
    // outside the allowed window is caught even where the counter agrees with it.
    a_done_window: assert property ( // see (R3)
        $rose(run_done_pulse_n)
        |-> $past(lowLen_reg) >= 28'(`EPT_DONE_MIN_MS * `EPT_MS_CYCLES)
            && $past(lowLen_reg) < 28'(`EPT_DONE_MAX_MS * `EPT_MS_CYCLES - 1))
        else $error("done pulse outside window");
    a_result_idle: assert property ( // see (R5) (R10)
        run_done_pulse_n |-> result_lines_n == `EPT_RESULT_IDLE)
        else $error("result active outside done");
    a_result_onehot: assert property ( // see (R5)
        !run_done_pulse_n |-> result_lines_n[`EPT_PASS_BIT] != result_lines_n[`EPT_NOTBLANK_BIT])
        else $error("result lines inconsistent in done");
    // The controller may sample at any point of the pulse, so the lines must not move.
    a_result_hold: assert property ( // see (R5)
        !run_done_pulse_n && !$past(run_done_pulse_n) |-> $stable(result_lines_n))
        else $error("result lines moved inside done");
    a_pass_report: assert property ( // see (R6)
        $fell(run_done_pulse_n) && !notBlank_reg |-> !result_lines_n[`EPT_PASS_BIT])
        else $error("pass not reported");
    a_notblank_report: assert property ( // see (R7)
        $fell(run_done_pulse_n) && notBlank_reg |-> !result_lines_n[`EPT_NOTBLANK_BIT])
        else $error("not blank not reported");
    a_jumper_gate: assert property (!jmpLvl_reg |-> !trigReq) // see (R8)
        else $error("trigger without jumper");
    // A done pulse may only follow a finish of a trigger run with the jumper shorted.
    a_done_source: assert property ( // see (R8) (R9)
        $fell(run_done_pulse_n)
        |-> $past(state_reg) == ept_pkg::EPT_RUN && $past(reportRun_reg) && $past(jmpLvl_reg))
        else $error("done pulse without a reporting run");
    a_button_start: assert property ( // see (R9)
        btnReq && state_reg == ept_pkg::EPT_IDLE |=> run_start && !reportRun_reg ##1 !run_start)
        else $error("button did not start");
    a_busy_ignore: assert property ( // see (R10)
        state_reg != ept_pkg::EPT_IDLE |=> !run_start) else $error("start during run");
    a_start_from_idle: assert property ( // see (R10)
        run_start |-> $past(state_reg) == ept_pkg::EPT_IDLE && $past(trigReq || btnReq))
        else $error("start without an idle request");
    a_reject_flag: assert property (rejectEv |=> irqStat_reg[`EPT_IRQ_REJECT]) // see (R10)
        else $error("ignored start not flagged");
    a_busy_state: assert property (run_busy == (state_reg == ept_pkg::EPT_RUN)) // see (R10)
        else $error("busy does not follow run");

    // ------------------------------------------------------------
    // Bus and interrupt checks
    // ------------------------------------------------------------
    // The interrupt is one register stage behind status, which keeps the pin glitch free.
    a_irq_level: assert property (irq == |($past(irqStat_reg) & $past(irqMask_reg)))
        else $error("interrupt does not follow status");
    a_pready_one: assert property (pready |=> !pready) else $error("pready held too long");
    a_slverr_ready: assert property (pslverr |-> pready) else $error("error without ready");

    c_trig_run: cover property (trigReq ##[1:300] finishReq);
    c_done_pass: cover property ($fell(run_done_pulse_n) && !result_lines_n[`EPT_PASS_BIT]);
    c_done_fail: cover property ($fell(run_done_pulse_n) && !result_lines_n[`EPT_NOTBLANK_BIT]);
    c_reject: cover property (rejectEv);
    c_button_run: cover property (btnReq ##1 run_start);

endmodule

// ==== ept_map.svh ====
// Offsets, field positions, reset values and timing counts of the program trigger handshake.
`ifndef EPT_MAP_SVH
`define EPT_MAP_SVH

`define EPT_CLK_HZ          20000000
// Start pulse width limits in milliseconds.
`define EPT_START_MIN_MS    10
`define EPT_START_MAX_MS    500
// Done pulse width limits in milliseconds and the width this block drives.
`define EPT_DONE_MIN_MS     12
`define EPT_DONE_MAX_MS     100
`define EPT_DONE_DRIVE_MS   50
`define EPT_MS_CYCLES       (`EPT_CLK_HZ / 1000)
`define EPT_START_MIN_CYC   (`EPT_START_MIN_MS * `EPT_MS_CYCLES)
`define EPT_START_MAX_CYC   (`EPT_START_MAX_MS * `EPT_MS_CYCLES)
`define EPT_DONE_CYC        (`EPT_DONE_DRIVE_MS * `EPT_MS_CYCLES)

// Register byte offsets.
`define EPT_OFF_CTRL        12'h000
`define EPT_OFF_STATUS      12'h004
`define EPT_OFF_IRQ_STAT    12'h008
`define EPT_OFF_IRQ_MASK    12'h00c
`define EPT_OFF_RESULT      12'h010

// Control fields.
`define EPT_CTRL_FINISH     0
`define EPT_CTRL_NOTBLANK   1
// Interrupt and result fields.
`define EPT_IRQ_START       0
`define EPT_IRQ_DONE        1
`define EPT_IRQ_REJECT      2
`define EPT_IRQ_W           3
`define EPT_RESULT_W        7
`define EPT_RESULT_IDLE     7'h7f
`define EPT_PASS_BIT        0
`define EPT_NOTBLANK_BIT    3

`endif

// ==== ept_pkg.sv ====
// Types of the program trigger handshake.
package ept_pkg;
    typedef enum logic [1:0] {
        EPT_IDLE = 2'b00,
        EPT_RUN  = 2'b01,
        EPT_DONE = 2'b10
    } ept_state_t;
    typedef logic [26:0] ept_cnt_t;
endpackage

// ==== ept_ctrl_model.sv ====
// External controller model that starts runs and collects the result lines.
`timescale 1ns/1ps

module ept_ctrl_model (
    // Clock.
    input  wire logic       clock,
    // Device pins.
    input  wire logic       run_done_pulse_n,
    input  wire logic [6:0] result_lines_n,
    output logic            ext_start_in_n
);
    logic [6:0] capturedResult = 7'h7f;
    logic       startLevel     = 1'b1;

    assign ext_start_in_n = startLevel;

    // The start pin is driven high by startLevel between requests.
    task automatic start_pulse(input int lowCycles);
        @(posedge clock);
        startLevel <= 1'b0;
        repeat (lowCycles) @(posedge clock);
        startLevel <= 1'b1;
    endtask

    // The result lines mean nothing outside the done pulse, so only then are they taken.
    always @(posedge clock) begin
        if (run_done_pulse_n === 1'b0) begin
            capturedResult <= result_lines_n;
        end
    end
endmodule

// ==== ept_trigger_handshake_tb_top.sv ====
// Self-checking testbench of the program trigger handshake.
`timescale 1ns/1ps
`include "ept_map.svh"

module ept_trigger_handshake_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clock;
    logic        sys_rst;
    logic        extStartN;
    logic        buttonN;
    logic        jumper;
    logic        doneN;
    logic [6:0]  resultsN;
    logic        runStart;
    logic        runBusy;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rdData;
    logic        rdErr;
    int          numErrors;
    int          nCompared;
    int          lowCnt;
    logic        doneOk;
    logic [11:0] rstAddr [6] = '{`EPT_OFF_CTRL, `EPT_OFF_STATUS, `EPT_OFF_IRQ_STAT,
                                 `EPT_OFF_IRQ_MASK, `EPT_OFF_RESULT, 12'h014};
    logic [31:0] rstVal [6]  = '{32'h0, 32'h8, 32'h0, 32'h0, 32'hff, 32'h0};
    logic        caseBlank [3] = '{1'b1, 1'b0, 1'b0};
    logic        caseJump [3]  = '{1'b1, 1'b1, 1'b0};
    logic [7:0]  casePins [3]  = '{8'h77, 8'h7e, 8'hff};

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ept_trigger_handshake DUT (
        .clock(clock), .sys_rst(sys_rst), .ext_start_in_n(extStartN), .button_in_n(buttonN),
        .digital_ctrl_enable_jumper(jumper), .run_done_pulse_n(doneN),
        .result_lines_n(resultsN), .run_start(runStart), .run_busy(runBusy), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    ept_ctrl_model ctrl (.clock(clock), .run_done_pulse_n(doneN), .result_lines_n(resultsN),
                         .ext_start_in_n(extStartN));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        if (numErrors == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(pready, 1'b1, "bus answer");
        if (pready !== 1'b1) complete_run();
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic err);
        apb(1'b0, addr, 32'h0);
        chk(rdData, exp, "read data");
        chk(rdErr, err, "slave error");
    endtask

    // Looks for the start pulse; a missing expected start ends the run.
    task automatic wait_start(input int bound, input logic expSeen);
        logic seen;
        seen = 1'b0;
        repeat (bound) begin
            @(posedge clock);
            if (runStart === 1'b1) seen = 1'b1;
        end
        chk(seen, expSeen, "run start");
        if (expSeen && !seen) complete_run();
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        chk({doneN, resultsN}, 8'hff, "idle pins");
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst   = 1'b1;
        buttonN   = 1'b1;
        jumper    = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        numErrors = 0;
        nCompared = 0;
        repeat (20) @(posedge clock);
        do_reset();
        foreach (rstAddr[i]) rd_chk(rstAddr[i], rstVal[i], i == 5);
        buttonN <= 1'b0;
        wait_start(20, 1'b1);
        chk(runBusy, 1'b1, "busy after button");
        buttonN <= 1'b1;
        repeat (8) @(posedge clock);
        // A second press while the run is open must be ignored and flagged.
        buttonN <= 1'b0;
        wait_start(20, 1'b0);
        buttonN <= 1'b1;
        apb(1'b1, `EPT_OFF_IRQ_MASK, 32'h7);
        repeat (3) @(posedge clock);
        chk(irq, 1'b1, "start interrupt");
        rd_chk(`EPT_OFF_IRQ_STAT, 32'h5, 1'b0);
        repeat (3) @(posedge clock);
        chk(irq, 1'b0, "interrupt after clear");
        apb(1'b1, `EPT_OFF_CTRL, 32'h1);
        repeat (3) @(posedge clock);
        chk({runBusy, doneN, resultsN}, 9'h0ff, "button run finish");
        ctrl.start_pulse(1000);
        wait_start(20, 1'b0);
        for (int i = 0; i < 3; i++) begin
            ctrl.start_pulse(210000);
            wait_start(20, 1'b1);
            jumper <= caseJump[i];
            // Lets the jumper level pass the pin synchroniser before the finish write.
            repeat (5) @(posedge clock);
            apb(1'b1, `EPT_OFF_CTRL, {30'h0, caseBlank[i], 1'b1});
            repeat (2) @(posedge clock);
            chk({doneN, resultsN}, casePins[i], "done pins");
            if (i == 0) begin
                // Two low cycles have passed already; the loop ends at the rise.
                lowCnt = 2;
                do begin
                    @(posedge clock);
                    if (doneN === 1'b0) lowCnt++;
                end while (doneN === 1'b0 && lowCnt < `EPT_DONE_MAX_MS * `EPT_MS_CYCLES);
                doneOk = lowCnt > `EPT_DONE_MIN_MS * `EPT_MS_CYCLES
                         && lowCnt < `EPT_DONE_MAX_MS * `EPT_MS_CYCLES;
                chk(doneOk, 1'b1, "done pulse width");
                chk({doneN, resultsN}, 8'hff, "pins after done");
                rd_chk(`EPT_OFF_IRQ_STAT, 32'h3, 1'b0);
            end
            if (i < 2) chk(ctrl.capturedResult, casePins[i][6:0], "captured result");
            jumper <= 1'b1;
            do_reset();
        end
        complete_run();
    end
endmodule
